// File: pkg/lrpm_params.svh
// Purpose: Constants for the reset and operating-mode controller and its host end.
// Assumes: sys_clk at 100 MHz.
// Notes: Times are kept in their own unit; cycle counts are derived from them.
`ifndef LRPM_PARAMS_SVH
`define LRPM_PARAMS_SVH
`define LRPM_CLK_MHZ 100
`define LRPM_POR_WAIT_US 5000
`define LRPM_POR_CYCLES (`LRPM_POR_WAIT_US * `LRPM_CLK_MHZ)
`define LRPM_SETTLE_US 10
`define LRPM_SETTLE_CYCLES (`LRPM_SETTLE_US * `LRPM_CLK_MHZ)
`define LRPM_STARTUP_MS 150
`define LRPM_STARTUP_CYCLES (`LRPM_STARTUP_MS * 1000 * `LRPM_CLK_MHZ)
`define LRPM_MODE_RESET 2'b00
`define LRPM_MODE_SLEEP 2'b10
`define LRPM_MODE_NORMAL 2'b11
`define LRPM_DISPLAY_BIT 2
`define LRPM_CTRL_DEFAULT 8'h00
`endif

// File: pkg/lrpm_pkg.sv
// Purpose: Types shared by the device end and the host end.
// Assumes: Nothing beyond the parameter header.
// Notes: Mode codes are the documented two-bit values.
package lrpm_pkg;
  typedef enum logic [1:0] {
    LRPM_CMD_NONE,
    LRPM_CMD_RESET,
    LRPM_CMD_DISPLAY
  } lrpm_cmd_t;
  typedef logic [1:0] lrpm_mode_t;
endpackage

// File: pkg/lrpm_if.sv
// Purpose: Command link between host and mode controller.
// Assumes: One clock for both ends.
// Notes: cmd_valid is a one-cycle pulse with its code and data.
interface lrpm_if (input wire logic sys_clk);
  logic cmd_valid;
  lrpm_pkg::lrpm_cmd_t cmd_code;
  logic [7:0] cmd_data;
  logic [1:0] mode;
  modport device (input cmd_valid, input cmd_code, input cmd_data, output mode);
  modport host (output cmd_valid, output cmd_code, output cmd_data, input mode);
endinterface

// File: hdl/lrpm_device.sv
// Purpose: Merges reset sources and holds the operating mode with its enables.
// Assumes: Ready flags and reset pin arrive asynchronously.
// Notes: All outputs are registered.
`include "lrpm_params.svh"
module lrpm_device #(
  parameter int POR_CYCLES = `LRPM_POR_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  lrpm_if.device link,
  input wire logic reset_pin_n,
  input wire logic vlcd_ready,
  input wire logic vbias_ready,
  input wire logic internal_vlcd_used,
  output logic clock_en,
  output logic pump_en,
  output logic driver_en,
  output logic drain_en,
  output logic drive_active,
  output logic trim_read_start,
  output logic sys_reset,
  output logic [7:0] ctrl_out
);
  ////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {LRPM_POR_WAIT, LRPM_RUN} lrpm_por_t;
  lrpm_por_t por_reg;
  logic [31:0] por_cnt_reg;
  logic [2:0] pin_sync_reg;
  logic pin_low_reg;
  logic [2:0] vl_sync_reg;
  logic [2:0] vb_sync_reg;
  logic vl_reg;
  logic vb_reg;
  logic [1:0] mode_reg;
  logic [1:0] mode_next;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic hw_reset;
  logic sw_reset;
  logic disp_cmd;
  logic por_fire;
  logic hw_q_reg;

  // Three-stage samplers; a change counts once the last two agree.
  always_ff @(posedge sys_clk)
  begin
    pin_sync_reg <= {pin_sync_reg[1:0], reset_pin_n};
    vl_sync_reg <= {vl_sync_reg[1:0], vlcd_ready};
    vb_sync_reg <= {vb_sync_reg[1:0], vbias_ready};
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pin_low_reg <= 1'b0;
      vl_reg <= 1'b0;
      vb_reg <= 1'b0;
    end
    else
    begin
      if (pin_sync_reg[2] == pin_sync_reg[1]) pin_low_reg <= ~pin_sync_reg[2];
      if (vl_sync_reg[2] == vl_sync_reg[1]) vl_reg <= vl_sync_reg[2];
      if (vb_sync_reg[2] == vb_sync_reg[1]) vb_reg <= vb_sync_reg[2];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Power-on wait counts the supply settle time before releasing the first reset.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      por_reg <= LRPM_POR_WAIT;
      por_cnt_reg <= 32'h0;
    end
    else
    begin
      case (por_reg)
        LRPM_POR_WAIT:
        begin
          por_cnt_reg <= por_cnt_reg + 32'h1;
          if (por_cnt_reg == 32'(POR_CYCLES - 1)) por_reg <= LRPM_RUN;
        end
        LRPM_RUN: por_cnt_reg <= por_cnt_reg;
        default: por_reg <= LRPM_POR_WAIT;
      endcase
    end
  end

  // Reset sources and the display command decode.
  assign por_fire = (por_reg == LRPM_POR_WAIT);
  assign hw_reset = por_fire | pin_low_reg;
  assign sw_reset = link.cmd_valid & (link.cmd_code == lrpm_pkg::LRPM_CMD_RESET);
  assign disp_cmd = link.cmd_valid & (link.cmd_code == lrpm_pkg::LRPM_CMD_DISPLAY);

  // Reset beats the display command; only these sources move the mode.
  assign mode_next = (hw_reset | sw_reset) ? `LRPM_MODE_RESET :
                     disp_cmd ? (link.cmd_data[`LRPM_DISPLAY_BIT] ? `LRPM_MODE_NORMAL
                                                                  : `LRPM_MODE_SLEEP) :
                     mode_reg;
  // A display command, sleep or normal, loads cmd_data into the settings; reset restores defaults.
  assign ctrl_next = (hw_reset | sw_reset) ? `LRPM_CTRL_DEFAULT :
                     disp_cmd ? link.cmd_data : ctrl_reg;

  ////////////////////////////////////////////////////////////////
  // Mode changes land on the clock edge after the command.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      mode_reg <= `LRPM_MODE_RESET;
      ctrl_reg <= `LRPM_CTRL_DEFAULT;
    end
    else
    begin
      mode_reg <= mode_next;
      ctrl_reg <= ctrl_next;
    end
  end

  // Enables decode from the held mode; drive_active also waits for both ready flags.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      clock_en <= 1'b0;
      pump_en <= 1'b0;
      driver_en <= 1'b0;
      drain_en <= 1'b0;
      drive_active <= 1'b0;
      trim_read_start <= 1'b0;
      sys_reset <= 1'b1;
      ctrl_out <= `LRPM_CTRL_DEFAULT;
      link.mode <= `LRPM_MODE_RESET;
    end
    else
    begin
      clock_en <= (mode_reg == `LRPM_MODE_NORMAL);
      pump_en <= (mode_reg == `LRPM_MODE_NORMAL);
      driver_en <= (mode_reg == `LRPM_MODE_NORMAL);
      // An external drive supply is never drained by this block.
      drain_en <= (mode_reg != `LRPM_MODE_NORMAL) & internal_vlcd_used;
      drive_active <= (mode_reg == `LRPM_MODE_NORMAL) & vl_reg & vb_reg;
      // Falling edge of a hardware reset starts the trim read; software reset does not.
      trim_read_start <= hw_reset_q_fall(hw_reset, hw_q_reg);
      sys_reset <= hw_reset | sw_reset;
      ctrl_out <= ctrl_reg;
      link.mode <= mode_reg;
    end
  end

  // Delayed hardware reset; it starts high so that leaving rst gives no false release edge.
  always_ff @(posedge sys_clk)
  begin
    if (rst) hw_q_reg <= 1'b1;
    else hw_q_reg <= hw_reset;
  end

  // A release edge of the hardware reset.
  function automatic logic hw_reset_q_fall(input logic now_v, input logic was_v);
    hw_reset_q_fall = was_v & ~now_v;
  endfunction
endmodule // lrpm_device

// File: hdl/lrpm_host.sv
// Purpose: Host end that waits for start-up, then sends mode commands.
// Assumes: User requests are single-cycle pulses.
// Notes: Requests arriving while busy are dropped; see busy.
`include "lrpm_params.svh"
module lrpm_host #(
  parameter int STARTUP_CYCLES = `LRPM_STARTUP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  lrpm_if.host link,
  input wire logic req_reset,
  input wire logic req_display,
  input wire logic [7:0] req_data,
  output logic busy,
  output logic [1:0] mode_seen
);
  ////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {LRPM_H_BOOT, LRPM_H_IDLE, LRPM_H_SETTLE} lrpm_h_t;
  lrpm_h_t st_reg;
  logic [31:0] cnt_reg;
  logic go_reset;
  logic go_disp;

  // Reset request wins over display request; both count as one command.
  assign go_reset = (st_reg == LRPM_H_IDLE) & req_reset;
  assign go_disp = (st_reg == LRPM_H_IDLE) & req_display & ~req_reset;

  // Power-down should go through go_reset so the drain circuit runs first.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_reg <= LRPM_H_BOOT;
      cnt_reg <= 32'h0;
      link.cmd_valid <= 1'b0;
      link.cmd_code <= lrpm_pkg::LRPM_CMD_NONE;
      link.cmd_data <= 8'h00;
      busy <= 1'b1;
      mode_seen <= `LRPM_MODE_RESET;
    end
    else
    begin
      link.cmd_valid <= go_reset | go_disp;
      link.cmd_code <= go_reset ? lrpm_pkg::LRPM_CMD_RESET :
                       go_disp ? lrpm_pkg::LRPM_CMD_DISPLAY : lrpm_pkg::LRPM_CMD_NONE;
      link.cmd_data <= go_disp ? req_data : 8'h00;
      mode_seen <= link.mode;
      case (st_reg)
        LRPM_H_BOOT:
        begin
          cnt_reg <= cnt_reg + 32'h1;
          if (cnt_reg == 32'(STARTUP_CYCLES - 1))
          begin
            st_reg <= LRPM_H_IDLE;
            cnt_reg <= 32'h0;
            busy <= 1'b0;
          end
        end
        LRPM_H_IDLE:
        begin
          if (go_reset | go_disp)
          begin
            st_reg <= LRPM_H_SETTLE;
            busy <= 1'b1;
          end
        end
        LRPM_H_SETTLE:
        begin
          cnt_reg <= cnt_reg + 32'h1;
          if (cnt_reg == 32'(`LRPM_SETTLE_CYCLES - 1))
          begin
            st_reg <= LRPM_H_IDLE;
            cnt_reg <= 32'h0;
            busy <= 1'b0;
          end
        end
        default: st_reg <= LRPM_H_BOOT;
      endcase
    end
  end
endmodule // lrpm_host

// File: dv/lrpm_checker.sv
// Purpose: Link checks for the mode controller.
// Assumes: Both link ends are design code on one clock.
// Notes: The mode follows a command two edges after it is taken.
module lrpm_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire lrpm_pkg::lrpm_cmd_t cmd_code,
  input wire logic [7:0] cmd_data,
  input wire logic [1:0] mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [10:0] gap_reg;
  logic is_disp;
  logic is_rst;
  ////////////////////////////////////////////////////////////
  // Decoded command kinds.
  assign is_disp = cmd_valid && cmd_code == lrpm_pkg::LRPM_CMD_DISPLAY;
  assign is_rst = cmd_valid && cmd_code == lrpm_pkg::LRPM_CMD_RESET;
  // Edges since the last command; starts saturated so the first one passes.
  always_ff @(posedge sys_clk)
  begin
    if (rst) gap_reg <= 11'h7ff;
    else if (cmd_valid) gap_reg <= 11'h000;
    else if (gap_reg != 11'h7ff) gap_reg <= gap_reg + 11'h001;
  end
  ////////////////////////////////////////////////////////////
  disp_on_a:
    assert property (is_disp && cmd_data[2] |-> ##2 mode == 2'b11) else $error("no normal mode");
  disp_off_a:
    assert property (is_disp && !cmd_data[2] |-> ##2 mode == 2'b10) else $error("no sleep mode");
  sw_reset_a:
    assert property (is_rst |-> ##2 (mode == 2'b00) [*4]) else $error("no reset mode");
  mode_code_a:
    assert property (mode != 2'b01) else $error("illegal mode code");
  por_hold_a:
    assert property ($fell(rst) |-> (mode == 2'b00) [*8]) else $error("mode left reset early");
  mode_cause_a:
    assert property ($changed(mode) && mode != 2'b00 |-> $past(cmd_valid, 2)) else $error("mode moved alone");
  cmd_pulse_a:
    assert property (cmd_valid |=> !cmd_valid && cmd_code == lrpm_pkg::LRPM_CMD_NONE) else $error("long command");
  cmd_gap_a:
    assert property (cmd_valid |-> gap_reg >= 11'h3e7) else $error("commands too close");
  cover property (is_disp && cmd_data[2]);
  cover property (is_disp && !cmd_data[2]);
  cover property (is_rst);
endmodule // lrpm_checker

// File: dv/lcd_reset_and_power_mode_control_tb.sv
// Purpose: Drives the host end against the device end and checks results.
// Assumes: Short start-up and power-on counts for a quick run.
// Notes: A model of mode and stored data is checked after each command.
module lcd_reset_and_power_mode_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rst, reset_pin_n, vlcd_ready, vbias_ready, internal_vlcd_used;
  logic req_reset, req_display, busy, clock_en, pump_en, driver_en, drain_en;
  logic drive_active, trim_read_start, sys_reset;
  logic [7:0] req_data, ctrl_out, regv;
  logic [1:0] mode_seen, m;
  int err_total, comparisons, seed, trims, exp_trims;
  lrpm_if u_lrpm_if (.sys_clk(sys_clk));
  lrpm_device #(.POR_CYCLES(20)) u_lrpm_device (.sys_clk, .rst, .link(u_lrpm_if), .reset_pin_n,
    .vlcd_ready, .vbias_ready, .internal_vlcd_used, .clock_en, .pump_en, .driver_en, .drain_en,
    .drive_active, .trim_read_start, .sys_reset, .ctrl_out);
  lrpm_host #(.STARTUP_CYCLES(50)) u_lrpm_host (.sys_clk, .rst, .link(u_lrpm_if), .req_reset,
    .req_display, .req_data, .busy, .mode_seen);
  lrpm_checker u_lrpm_checker (.sys_clk(sys_clk), .rst(rst), .cmd_valid(u_lrpm_if.cmd_valid),
    .cmd_code(u_lrpm_if.cmd_code), .cmd_data(u_lrpm_if.cmd_data), .mode(u_lrpm_if.mode));
  ////////////////////////////////////////////////////////////
  // Clock and trim pulse counting.
  initial
  begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (trim_read_start === 1'b1) trims++;
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Inputs always change one nanosecond after the rising edge.
  task automatic step(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Bounded wait for the host to accept requests again.
  task automatic settle;
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 3000)
    begin
      step(1);
      k++;
    end
    if (k == 3000) err_total++;
  endtask
  // Pulses one request; the model only moves when the host will take it.
  task automatic send(logic rs, logic [7:0] dv, logic take);
    req_reset = rs;
    req_display = !rs;
    req_data = dv;
    step(1);
    req_reset = 0;
    req_display = 0;
    if (take) regv = rs ? 8'h00 : dv;
    if (take) m = rs ? 2'b00 : (dv[2] ? 2'b11 : 2'b10);
  endtask
  task automatic check_all;
    chk(u_lrpm_if.mode, m);
    chk(mode_seen, m);
    chk(clock_en, m == 2'b11);
    chk(pump_en, m == 2'b11);
    chk(driver_en, m == 2'b11);
    chk(drain_en, m != 2'b11 && internal_vlcd_used);
    chk(drive_active, m == 2'b11 && vlcd_ready);
    chk(ctrl_out, regv);
    chk(trims, exp_trims);
    chk(sys_reset, 0);
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence: start-up, fixed modes, random commands, ready flag, pin.
  initial
  begin
    seed = 32'h15fa1c3b;
    {rst, reset_pin_n, vlcd_ready, vbias_ready, internal_vlcd_used} = 5'h1f;
    {req_reset, req_display, req_data} = 10'h000;
    {m, regv, exp_trims} = 0;
    step(2);
    rst = 0;
    step(1);
    chk(busy, 1);
    send(0, 8'h04, 0);
    settle;
    exp_trims = 1;
    check_all;
    send(0, 8'h24, 1);
    settle;
    check_all;
    send(0, 8'ha1, 1);
    settle;
    check_all;
    send(1, 8'h00, 1);
    settle;
    check_all;
    repeat (6)
    begin
      internal_vlcd_used = $random(seed);
      send($random(seed) % 4 == 0, $random(seed), 1);
      settle;
      check_all;
    end
    send(0, 8'h0c, 1);
    settle;
    vlcd_ready = 0;
    step(8);
    check_all;
    vlcd_ready = 1;
    reset_pin_n = 0;
    step(8);
    {m, regv} = 0;
    reset_pin_n = 1;
    exp_trims++;
    step(40);
    check_all;
    end_sim;
  end
  // Watchdog well beyond the expected run of about 10100 cycles.
  initial
  begin
    step(40000);
    err_total++;
    end_sim;
  end
endmodule // lcd_reset_and_power_mode_control_tb
